// file: verilog/sinc3_decimation_filter.sv
// sinc-cubed decimation filter with normaliser, settling control and apb registers
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module sinc3_decimation_filter #(
   parameter int                            MOD_DIV     = sinc3_pkg::MOD_DIV_DEF,
   parameter int                            ACC_W       = sinc3_pkg::ACC_W_DEF,
   parameter logic [sinc3_pkg::NOTCH_W-1:0] NOTCH_RESET = sinc3_pkg::NOTCH_RST
)(
   // clock and reset
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_resetn,
   // apb slave
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [7:0]                i_paddr,
   input  wire logic [31:0]               i_pwdata,
   output logic      [31:0]               o_prdata,
   output logic                           o_pready,
   output logic                           o_pslverr,
   // modulator and sync pin
   input  wire logic                      i_mod_bit,
   input  wire logic                      i_sync_n,
   // channel and data status
   output logic      [sinc3_pkg::CH_W-1:0] o_channel,
   output logic                           o_data_ready
);
   import sinc3_pkg::*;

   localparam int REM_W = ACC_W + 1;
   localparam int DEN_W = 3 * NOTCH_W;
   localparam int NCH   = 1 << CH_W;

   // room for a full-density word at the largest N, so nothing saturates
   if (ACC_W < DEN_W + 1)
   begin : g_chk_acc
      $error("sinc3_decimation_filter: ACC_W too small for N cubed");
   end
   if (MOD_DIV < QUO_W + 4)
   begin : g_chk_div
      $error("sinc3_decimation_filter: MOD_DIV too small for the divider");
   end

   if (NOTCH_RESET == '0)
   begin : g_chk_notch
      $error("sinc3_decimation_filter: NOTCH_RESET must be nonzero");
   end

   if ((1 << STEP_W) < QUO_W)
   begin : g_chk_step
      $error("sinc3_decimation_filter: STEP_W cannot count the quotient bits");
   end

   if (CODE_W > QUO_W - 3)
   begin : g_chk_code
      $error("sinc3_decimation_filter: CODE_W wider than the quotient allows");
   end

   typedef struct packed
   {
      logic                 sync_meta;
      logic                 sync_lvl;
      logic                 align;
      logic [CH_W-1:0]      channel;
      logic [NOTCH_W-1:0]   notch;
      logic [NCH-1:0]       unipolar;
      logic                 word24;
      logic                 restart;
      div_state_t           div_st;
      logic [REM_W-1:0]     rem;
      logic [DEN_W-1:0]     den;
      logic [QUO_W-1:0]     quo;
      logic [STEP_W-1:0]    step;
      logic [1:0]           settle;
      logic [CODE_W-1:0]    data;
      logic                 ready;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
   } top_state_t;

   top_state_t st_reg;
   top_state_t st_next;

   logic               tick;
   logic               core_clear;
   logic [NOTCH_W-1:0] n_eff;
   logic [ACC_W-1:0]   core_sum;
   logic               core_valid;
   logic [DEN_W-1:0]   n_cubed;

   // a zero notch word would make the decimator count 4096 and n_cubed zero, so it runs as one
   assign n_eff = (st_reg.notch == '0) ? NOTCH_W'(1) : st_reg.notch;
   // n cubed is the dc gain of the three stages; dividing by it yields density
   assign n_cubed = DEN_W'(n_eff) * DEN_W'(n_eff) * DEN_W'(n_eff);

   // held clear while the pin is low or the align bit is set, and for one clock on each restart pulse
   assign core_clear = !st_reg.sync_lvl || st_reg.align || st_reg.restart;

   sample_tick #(
      .DIV      (MOD_DIV)
   ) u_tick (
      .i_ref_clk(i_ref_clk),
      .i_resetn (i_resetn),
      .o_tick   (tick)
   );

   // lag-N combs after three integrators: zeros at every multiple of the word rate
   // the response shape is fixed, so cutoff and delay simply scale with N
   sinc3_core #(
      .ACC_W    (ACC_W)
   ) u_core (
      .i_ref_clk(i_ref_clk),
      .i_resetn (i_resetn),
      .i_clear  (core_clear),
      .i_tick   (tick),
      .i_bit    (i_mod_bit),
      .i_n      (n_eff),
      .o_sum    (core_sum),
      .o_valid  (core_valid)
   );

   // output coding from the 33-bit normalised quotient
   function automatic logic [CODE_W-1:0] code_of(input logic [QUO_W-1:0] q,
                                                 input logic uni);
      logic [QUO_W-1:0] t;
      logic [CODE_W-1:0] c;
      t = '0;
      c = '0;
      if (uni)
      begin
         // unipolar: lower half of the bitstream density maps to zero
         if (q[QUO_W-1:QUO_W-2] != 2'b00)
            t = q - {2'b01, {(QUO_W-2){1'b0}}};
         if (t[QUO_W-1:QUO_W-2] != 2'b00)
            c = '1;
         else
            c = t[QUO_W-3 -: CODE_W];
      end
      else
      begin
         // bipolar: offset binary, mid-scale at half density
         if (q[QUO_W-1])
            c = '1;
         else
            c = q[QUO_W-2 -: CODE_W];
      end
      return c;
   endfunction

   always_comb
   begin
      logic [REM_W-1:0]  trial;
      logic              qbit;
      logic [CODE_W-1:0] code;
      logic              setup;
      logic              access;
      logic              data_rd;
      logic [CH_W-1:0]   new_ch;
      logic [NOTCH_W-1:0] new_notch;
      trial = '0;
      qbit = 1'b0;
      code = '0;
      new_ch = '0;
      new_notch = '0;
      setup = i_psel && !i_penable;
      access = i_psel && i_penable && st_reg.pready;
      data_rd = access && !i_pwrite && (i_paddr == DATA_OFS);
      st_next = st_reg;
      st_next.restart = 1'b0;

      // two-stage synchroniser on the sync pin
      st_next.sync_meta = i_sync_n;
      st_next.sync_lvl = st_reg.sync_meta;

      // ready flag: reading the data register clears it
      if (data_rd)
         st_next.ready = 1'b0;

      // normaliser: restoring divide of the comb sum by N cubed
      case (st_reg.div_st)
         DIV_IDLE:
         begin
            if (core_valid)
            begin
               st_next.rem = REM_W'(core_sum);
               st_next.den = n_cubed;
               st_next.quo = '0;
               st_next.step = '0;
               st_next.div_st = DIV_RUN;
            end
         end
         DIV_RUN:
         begin
            // one quotient bit per clock; 33 clocks fit well inside one sample tick
            // the remainder is one bit wider so the shift never loses its top bit
            trial = st_reg.rem - REM_W'(st_reg.den);
            qbit = (st_reg.rem >= REM_W'(st_reg.den));
            if (qbit)
               st_next.rem = REM_W'(trial << 1);
            else
               st_next.rem = REM_W'(st_reg.rem << 1);
            st_next.quo = {st_reg.quo[QUO_W-2:0], qbit};
            st_next.step = st_reg.step + 1'b1;
            if (st_reg.step == STEP_W'(QUO_W - 1))
               st_next.div_st = DIV_DONE;
         end
         DIV_DONE:
         begin
            code = code_of(st_reg.quo, st_reg.unipolar[st_reg.channel]);
            // early words after a restart are partial sums and are dropped
            if (st_reg.settle >= 2'(SETTLE_WORDS - 1))
            begin
               if (st_reg.word24)
                  st_next.data = code;
               else
                  st_next.data = {8'h00, code[CODE_W-1 -: 16]};
               // set wins: a word landing with a data read keeps ready high
               st_next.ready = 1'b1;
            end
            // count saturates at the target so long runs never wrap back
            if (st_reg.settle != 2'(SETTLE_WORDS))
               st_next.settle = st_reg.settle + 1'b1;
            st_next.div_st = DIV_IDLE;
         end
         default:
         begin
            st_next.div_st = DIV_IDLE;
         end
      endcase

      // register map: ctrl holds channel and align, the filter pair holds N,
      // word length and the current channel's polarity; status and data read only
      // writes to status or data are dropped quietly, unmapped ones raise an error
      // apb: answer one cycle after setup
      st_next.pready = 1'b0;
      if (setup)
      begin
         st_next.pready = 1'b1;
         st_next.pslverr = 1'b0;
         st_next.prdata = '0;
         case (i_paddr)
            CTRL_OFS:
            begin
               st_next.prdata[CTRL_CH_LSB +: CH_W] = st_reg.channel;
               st_next.prdata[CTRL_ALIGN_BIT] = st_reg.align;
            end
            FLT_LO_OFS:
            begin
               st_next.prdata[7:0] = st_reg.notch[7:0];
            end
            FLT_HI_OFS:
            begin
               st_next.prdata[FLT_HI_NOTCH_LSB +: 4] = st_reg.notch[NOTCH_W-1:8];
               st_next.prdata[FLT_HI_WL_BIT] = st_reg.word24;
               st_next.prdata[FLT_HI_UNI_BIT] = st_reg.unipolar[st_reg.channel];
            end
            STATUS_OFS:
            begin
               st_next.prdata[STAT_READY_BIT] = st_reg.ready;
               // settling also covers the unaligned-step case
               st_next.prdata[STAT_SETTLE_BIT] = (st_reg.settle != 2'(SETTLE_WORDS));
               st_next.prdata[STAT_BUSY_BIT] = (st_reg.div_st != DIV_IDLE);
            end
            DATA_OFS:
            begin
               st_next.prdata[CODE_W-1:0] = st_reg.data;
            end
            default:
            begin
               st_next.pslverr = 1'b1;
            end
         endcase
      end

      if (access && i_pwrite)
      begin
         case (i_paddr)
            CTRL_OFS:
            begin
               new_ch = i_pwdata[CTRL_CH_LSB +: CH_W];
               st_next.align = i_pwdata[CTRL_ALIGN_BIT];
               st_next.channel = new_ch;
               if (new_ch != st_reg.channel)
                  st_next.restart = 1'b1;
            end
            FLT_LO_OFS:
            begin
               new_notch = {st_reg.notch[NOTCH_W-1:8], i_pwdata[7:0]};
               st_next.notch = new_notch;
               if (new_notch != st_reg.notch)
                  st_next.restart = 1'b1;
            end
            FLT_HI_OFS:
            begin
               new_notch = {i_pwdata[FLT_HI_NOTCH_LSB +: 4], st_reg.notch[7:0]};
               st_next.notch = new_notch;
               st_next.word24 = i_pwdata[FLT_HI_WL_BIT];
               st_next.unipolar[st_reg.channel] = i_pwdata[FLT_HI_UNI_BIT];
               if (new_notch != st_reg.notch)
                  st_next.restart = 1'b1;
            end
            default:
            begin
            end
         endcase
      end

      // any filter clear discards a pending word not yet in DIV_DONE and restarts settling
      // the clear also beats a word the divider is still working on
      if (core_clear)
      begin
         st_next.settle = '0;
         st_next.div_st = DIV_IDLE;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st_reg <= '0;
         // sync stages start at the idle pin level so release looks like no sync
         st_reg.sync_meta <= 1'b1;
         st_reg.sync_lvl <= 1'b1;
         st_reg.channel <= CH_RST;
         st_reg.notch <= NOTCH_RESET;
         st_reg.word24 <= WL_RST;
         st_reg.unipolar <= {NCH{UNI_RST}};
         st_reg.div_st <= DIV_IDLE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_prdata = st_reg.prdata;
   assign o_pready = st_reg.pready;
   assign o_pslverr = st_reg.pslverr;
   assign o_channel = st_reg.channel;
   assign o_data_ready = st_reg.ready;

endmodule

// file: inc/sinc3_pkg.sv
// shared constants for the third-order sinc decimation filter
package sinc3_pkg;

   // rates and widths
   localparam int MOD_DIV_DEF  = 128;
   localparam int NOTCH_W      = 12;
   localparam int ACC_W_DEF    = 40;
   localparam int QUO_W        = 33;
   localparam int CODE_W       = 24;
   localparam int CH_W         = 3;
   localparam int SETTLE_WORDS = 3;
   localparam int STEP_W       = 6;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] FLT_LO_OFS = 8'h04;
   localparam logic [7:0] FLT_HI_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] DATA_OFS   = 8'h10;

   // field positions
   localparam int CTRL_CH_LSB      = 0;
   localparam int CTRL_ALIGN_BIT   = 4;
   localparam int FLT_HI_NOTCH_LSB = 0;
   localparam int FLT_HI_WL_BIT    = 6;
   localparam int FLT_HI_UNI_BIT   = 7;
   localparam int STAT_READY_BIT   = 0;
   localparam int STAT_SETTLE_BIT  = 1;
   localparam int STAT_BUSY_BIT    = 2;

   // reset values
   localparam logic [NOTCH_W-1:0] NOTCH_RST = 12'h180;
   localparam logic [CH_W-1:0]    CH_RST    = 3'h0;
   localparam logic               WL_RST    = 1'b1;
   localparam logic               UNI_RST   = 1'b0;

   typedef enum logic [1:0]
   {
      DIV_IDLE = 2'b00,
      DIV_RUN  = 2'b01,
      DIV_DONE = 2'b11
   } div_state_t;

endpackage

// file: verilog/sample_tick.sv
// modulator sample enable: one pulse every DIV clocks
`timescale 1ns/10ps
module sample_tick #(
   parameter int DIV = sinc3_pkg::MOD_DIV_DEF
)(
   // clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_resetn,
   // enable out
   output logic      o_tick
);
   import sinc3_pkg::*;

   localparam int CW = $clog2(DIV);

   typedef struct packed
   {
      logic [CW-1:0] cnt;
      logic          tick;
   } tick_state_t;

   tick_state_t st_reg;
   tick_state_t st_next;

   if (DIV < 2)
   begin : g_chk
      $error("sample_tick: DIV must be at least 2");
   end

   always_comb
   begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.cnt == CW'(DIV - 1))
      begin
         st_next.cnt = '0;
         st_next.tick = 1'b1;
      end
      else
      begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign o_tick = st_reg.tick;

endmodule

// file: verilog/sinc3_core.sv
// three integrators, decimator and three combs
`timescale 1ns/10ps
module sinc3_core #(
   parameter int ACC_W = sinc3_pkg::ACC_W_DEF
)(
   // clock and reset
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_resetn,
   // control
   input  wire logic                         i_clear,
   input  wire logic                         i_tick,
   input  wire logic                         i_bit,
   input  wire logic [sinc3_pkg::NOTCH_W-1:0] i_n,
   // result
   output logic [ACC_W-1:0]                  o_sum,
   output logic                              o_valid
);
   import sinc3_pkg::*;

   typedef struct packed
   {
      logic [2:0][ACC_W-1:0] integ;
      logic [2:0][ACC_W-1:0] dly;
      logic [NOTCH_W-1:0]    dec_cnt;
      logic [ACC_W-1:0]      sum;
      logic                  valid;
   } core_state_t;

   core_state_t st_reg;
   core_state_t st_next;

   always_comb
   begin
      logic [ACC_W-1:0] comb_v;
      comb_v = '0;
      st_next = st_reg;
      st_next.valid = 1'b0;
      if (i_clear)
      begin
         st_next = '0;
      end
      else if (i_tick)
      begin
         // wraparound sums are exact as long as ACC_W covers the full gain
         st_next.integ[0] = st_reg.integ[0] + ACC_W'(i_bit);
         for (int k = 1; k < 3; k++)
            st_next.integ[k] = st_reg.integ[k] + st_reg.integ[k-1];
         if (st_reg.dec_cnt >= i_n - 1'b1)
         begin
            st_next.dec_cnt = '0;
            comb_v = st_next.integ[2];
            for (int k = 0; k < 3; k++)
            begin
               st_next.dly[k] = comb_v;
               comb_v = comb_v - st_reg.dly[k];
            end
            st_next.sum = comb_v;
            st_next.valid = 1'b1;
         end
         else
         begin
            st_next.dec_cnt = st_reg.dec_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign o_sum = st_reg.sum;
   assign o_valid = st_reg.valid;

endmodule

// file: tb/sinc3_filter_props.sv
// port-level assertions for the sinc3 decimation filter
`timescale 1ns/10ps
module sinc3_filter_props
   import sinc3_pkg::*;
#(
   parameter int MOD_DIV = MOD_DIV_DEF
)(
   // clock and reset
   input wire logic                      i_ref_clk,
   input wire logic                      i_resetn,
   // apb
   input wire logic                      i_psel,
   input wire logic                      i_penable,
   input wire logic                      i_pwrite,
   input wire logic [7:0]                i_paddr,
   input wire logic [31:0]               i_pwdata,
   input wire logic [31:0]               o_prdata,
   input wire logic                      o_pready,
   input wire logic                      o_pslverr,
   // stream side
   input wire logic                      i_mod_bit,
   input wire logic                      i_sync_n,
   input wire logic [sinc3_pkg::CH_W-1:0] o_channel,
   input wire logic                      o_data_ready
);
   logic        wr_ctrl;
   logic        setup;
   logic        mapped;
   logic        rdy_q;
   logic [15:0] since_rst;
   logic [15:0] since_word;

   assign wr_ctrl = i_psel && i_penable && o_pready && i_pwrite && i_paddr == CTRL_OFS;
   assign setup   = i_psel && !i_penable;
   assign mapped  = i_paddr inside {CTRL_OFS, FLT_LO_OFS, FLT_HI_OFS, STATUS_OFS, DATA_OFS};

   // saturating counters: a later restart only delays data, so the bounds stay safe
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rdy_q      <= 1'b0;
         since_rst  <= '0;
         since_word <= '0;
      end
      else
      begin
         rdy_q      <= o_data_ready;
         since_rst  <= (wr_ctrl || !i_sync_n) ? '0 : since_rst + 16'(since_rst != 16'hffff);
         since_word <= (o_data_ready && !rdy_q) ? '0 : since_word + 16'(since_word != 16'hffff);
      end
   end

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);

   a_pready_pulse: assert property (o_pready |=> !o_pready)
      else $error("pready held longer than one cycle");
   a_pready_setup: assert property (setup |=> o_pready)
      else $error("no pready after setup");
   a_pready_idle: assert property (!i_psel |=> !o_pready)
      else $error("pready without select");
   a_err_unmapped: assert property (setup && !mapped |=> o_pslverr && (i_pwrite || o_prdata == 0))
      else $error("unmapped access not refused");
   a_err_mapped: assert property (setup && mapped |=> !o_pslverr)
      else $error("error on mapped access");
   a_channel_write: assert property (wr_ctrl |=> o_channel == $past(i_pwdata[CH_W-1:0]))
      else $error("channel not taken from write");
   a_restart_hold: assert property ($rose(o_data_ready) |-> since_rst >= 2*MOD_DIV-1)
      else $error("data ready too soon after restart");
   a_word_spacing: assert property ($rose(o_data_ready) |-> since_word >= MOD_DIV-1)
      else $error("words closer than one sample period");
   a_read_clears: assert property (i_psel && i_penable && o_pready && !i_pwrite
                                   && i_paddr == DATA_OFS |=> !o_data_ready)
      else $error("data ready not cleared by read");
endmodule

bind sinc3_decimation_filter sinc3_filter_props #(.MOD_DIV(MOD_DIV)) sinc3_filter_props_inst (
   .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_mod_bit(i_mod_bit), .i_sync_n(i_sync_n),
   .o_channel(o_channel), .o_data_ready(o_data_ready));

// file: tb/mod_model.sv
// modulator stand-in: bitstream of constant density 0 or 1
`timescale 1ns/10ps
module mod_model (
   // clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_resetn,
   // density select and bitstream
   input  wire logic i_level,
   output logic      o_bit
);
   // registered so the bit changes just after an edge
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_bit <= 1'b0;
      else
         o_bit <= i_level;
   end
endmodule

// file: tb/sinc3_decimation_filter_tb.sv
// self-checking bench for the sinc3 decimation filter
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module sinc3_decimation_filter_tb;
   import sinc3_pkg::*;
   localparam int       MD    = 40;
   localparam int       NS[5] = '{2, 2, 3, 3, 5};
   localparam int       KD[5] = '{0, 1, 2, 0, 0};
   localparam bit [4:0] LV    = 5'b10101;
   localparam bit [4:0] UN    = 5'b01100;
   localparam bit [4:0] WL    = 5'b01011;
   logic              i_ref_clk = 1'b0;
   logic              i_resetn  = 1'b0;
   logic              i_psel    = 1'b0;
   logic              i_penable = 1'b0;
   logic              i_pwrite  = 1'b0;
   logic [7:0]        i_paddr   = 8'h00;
   logic [31:0]       i_pwdata  = 32'h0;
   logic              i_sync_n  = 1'b1;
   logic              i_level   = 1'b0;
   logic [31:0]       o_prdata;
   logic              o_pready;
   logic              o_pslverr;
   logic              mod_bit;
   logic [CH_W-1:0]   o_channel;
   logic              o_data_ready;
   int                checked    = 0;
   int                mismatches = 0;

   always #5 i_ref_clk = ~i_ref_clk;

   sinc3_decimation_filter #(.MOD_DIV(MD)) sinc3_decimation_filter_inst (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_mod_bit(mod_bit), .i_sync_n(i_sync_n),
      .o_channel(o_channel), .o_data_ready(o_data_ready));
   mod_model mod_model_inst (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_level(i_level),
      .o_bit(mod_bit));

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      i_psel    <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite  <= wr;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      do
      begin
         @(posedge i_ref_clk);
         n++;
      end
      while (o_pready !== 1'b1);
      q = o_prdata;
      e = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   // one edge first: a read just issued clears ready only at its own edge
   task automatic wait_rdy(output time t);
      int n;
      n = 0;
      do
      begin
         @(posedge i_ref_clk);
         n++;
      end
      while (o_data_ready !== 1'b1 && n < 5000);
      t = $time;
   endtask

   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #400000;
      mismatches++;
      conclude();
   end

   initial
   begin
      logic [31:0] q;
      logic        e;
      logic [31:0] ex;
      time         t0;
      time         t1;
      int          n;
      repeat (16) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0, q, e);
      `CHK("ctrl reset", 32'h0, q)
      apb(1'b0, FLT_LO_OFS, 32'h0, q, e);
      `CHK("flt_lo reset", 32'h80, q)
      apb(1'b0, FLT_HI_OFS, 32'h0, q, e);
      `CHK("flt_hi reset", 32'h41, q)
      apb(1'b0, 8'h14, 32'h0, q, e);
      `CHK("unmapped read", 33'h1_0000_0000, {e, q})
      apb(1'b1, 8'h14, 32'hffff_ffff, q, e);
      `CHK("unmapped write", 1'b1, e)
      for (int k = 0; k < 5; k++)
      begin
         n  = NS[k];
         ex = LV[k] ? (WL[k] ? 32'hff_ffff : 32'hffff) : 32'h0;
         i_level <= LV[k];
         wr(CTRL_OFS, 32'(k));
         wr(FLT_HI_OFS, {24'h0, UN[k], WL[k], 6'h0});
         wr(FLT_LO_OFS, 32'(n));
         // switch away and back so each case restarts on a channel change, except the KD 2 case, which restarts through the align bit
         wr(CTRL_OFS, KD[k] == 2 ? 32'h10 | 32'(k) : 32'h7);
         wr(CTRL_OFS, 32'(k));
         if (KD[k] == 1)
         begin
            i_sync_n <= 1'b0;
            repeat (20) @(posedge i_ref_clk);
            i_sync_n <= 1'b1;
         end
         apb(1'b0, STATUS_OFS, 32'h0, q, e);
         `CHK("status settling", 32'h2, q)
         t0 = $time;
         wait_rdy(t1);
         `CHK("holdoff", 1'b1, (t1-t0)/10 >= (3*n-1)*MD && (t1-t0)/10 <= 3*n*MD+60)
         `CHK("channel", 3'(k), o_channel)
         apb(1'b0, STATUS_OFS, 32'h0, q, e);
         `CHK("status settled", 33'h0_0000_0001, {e, q})
         apb(1'b0, DATA_OFS, 32'h0, q, e);
         `CHK("first word", ex, q)
         wait_rdy(t0);
         `CHK("word period", n*MD, int'((t0-t1)/10))
         apb(1'b0, DATA_OFS, 32'h0, q, e);
         `CHK("steady word", ex, q)
         @(posedge i_ref_clk);
         `CHK("ready cleared", 1'b0, o_data_ready)
      end
      conclude();
   end
endmodule
